//--- src/alu_flags_and_conditions.sv
`timescale 1ns/1ns
`default_nettype none
`include "alu_flags_cfg.svh"

module alu_flags_and_conditions #(
  parameter int PORT_W = `PORT_W
) (
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [`APB_ADDR_W-1:0]         paddr,
  input  wire logic [`APB_DATA_W-1:0]         pwdata,
  output logic [`APB_DATA_W-1:0]              prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire alu_flags_pkg::alu_result_t     aluResult,
  input  wire logic                           loopLevelInc,
  input  wire logic                           loopLevelDec,
  input  wire alu_flags_pkg::cond_req_t       condReq,
  output logic                                condValid,
  output logic                                condResult,
  input  wire alu_flags_pkg::accum_zero_req_t zeroReq,
  output logic                                zeroValid,
  output logic [`RESULT_W-1:0]                zeroValue,
  input  wire logic [PORT_W-1:0]              portPins,
  output alu_flags_pkg::condition_flags_t     flagsOut
);

  alu_flags_pkg::condition_flags_t flags_reg;
  alu_flags_pkg::condition_flags_t flags_next;
  logic [PORT_W-1:0]               portSens_reg;
  logic [PORT_W-1:0]               portLevel_reg;
  logic [PORT_W-1:0]               portEdge_reg;
  logic [PORT_W-1:0]               portEdge_next;
  logic [PORT_W-1:0]               portTestClear;
  logic [PORT_W-1:0]               portValue;
  logic                            apbAccess;
  logic                            apbWrite;
  logic                            flagsWrite;
  logic                            sensWrite;
  logic                            condHit;
  logic                            testStickyOvf;
  logic                            testStickyNrm;
  logic [`RESULT_W-1:0]            res;
  logic                            resNormalized;
  logic                            resBeyond32;

  // decoded register word; unmapped offsets are flagged by the caller
  function automatic logic mapped(input logic [`APB_ADDR_W-1:0] a);
    mapped = (a == `OFF_FLAGS) || (a == `OFF_PORT_SENS) ||
             (a == `OFF_PORT_STATE);
  endfunction

  // true test of the selected condition, before inversion
  function automatic logic evalCond(
    input alu_flags_pkg::cond_sel_t       s,
    input alu_flags_pkg::condition_flags_t f,
    input logic [PORT_W-1:0]              p
  );
    logic lessThan;
    lessThan = f.sign ^ f.overflowFlag;
    unique case (s)
      alu_flags_pkg::COND_ALWAYS:  evalCond = 1'b1;
      alu_flags_pkg::COND_ZERO:    evalCond = f.zero;
      alu_flags_pkg::COND_LESS:    evalCond = lessThan;
      alu_flags_pkg::COND_AT_MOST:
        evalCond = lessThan | f.zero;
      alu_flags_pkg::COND_CARRY:   evalCond = f.carry;
      alu_flags_pkg::COND_SIGN:    evalCond = f.sign;
      alu_flags_pkg::COND_EXT:     evalCond = f.beyond32Flag;
      alu_flags_pkg::COND_OVF:     evalCond = f.overflowFlag;
      alu_flags_pkg::COND_STK_OVF: evalCond = f.stickyOverflow;
      alu_flags_pkg::COND_NORM:    evalCond = f.normalized;
      alu_flags_pkg::COND_STK_NRM: evalCond = f.stickyNormalized;
      alu_flags_pkg::COND_BIT16:   evalCond = f.resultBit16Flag;
      alu_flags_pkg::COND_CARRY31: evalCond = f.carryOutMid;
      alu_flags_pkg::COND_TEST:    evalCond = f.testResult;
      alu_flags_pkg::COND_PORT0:   evalCond = p[0];
      alu_flags_pkg::COND_PORT1:   evalCond = p[1];
      alu_flags_pkg::COND_PORT2:   evalCond = p[2];
      alu_flags_pkg::COND_PORT3:   evalCond = p[3];
      alu_flags_pkg::COND_PORT4:   evalCond = p[4];
      alu_flags_pkg::COND_PORT5:   evalCond = p[5];
      alu_flags_pkg::COND_PORT6:   evalCond = p[6];
      alu_flags_pkg::COND_PORT7:   evalCond = p[7];
      default:                     evalCond = 1'b0;
    endcase
  endfunction

  // apb decode
  assign apbAccess  = psel && penable && pready;
  assign apbWrite   = apbAccess && pwrite && !pslverr;
  assign flagsWrite = apbWrite && (paddr == `OFF_FLAGS);
  assign sensWrite  = apbWrite && (paddr == `OFF_PORT_SENS);

  // apb answer one cycle into the access phase
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped(paddr);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFF_FLAGS:      prdata <= {16'h0000, flags_reg};
        `OFF_PORT_SENS:  prdata <= {{(`APB_DATA_W-PORT_W){1'b0}},
                                    portSens_reg};
        `OFF_PORT_STATE: prdata <= {{(`APB_DATA_W-PORT_W){1'b0}},
                                    portValue};
        default:         prdata <= '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      portSens_reg <= '0;
    end else if (sensWrite) begin
      portSens_reg <= pwdata[PORT_W-1:0];
    end
  end

  // port sampling and falling-edge capture
  assign condHit = condReq.valid &&
                   (condReq.sel >= alu_flags_pkg::COND_PORT0);

  generate
    for (genvar i = 0; i < PORT_W; i++) begin : g_port
      assign portTestClear[i] = condHit &&
        (condReq.sel[2:0] == 3'(i));
      // set wins over the clear from a test in the same cycle
      assign portEdge_next[i] =
        (portLevel_reg[i] && !portPins[i]) ||
        (portEdge_reg[i] && !portTestClear[i]);
      assign portValue[i] = portSens_reg[i] ? portEdge_reg[i]
                                            : portLevel_reg[i];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      portLevel_reg <= '0;
      portEdge_reg  <= '0;
    end else begin
      portLevel_reg <= portPins;
      portEdge_reg  <= portEdge_next & portSens_reg;
    end
  end

  // condition evaluation
  always_ff @(posedge clk) begin
    if (reset) begin
      condValid  <= 1'b0;
      condResult <= 1'b0;
    end else begin
      condValid  <= condReq.valid;
      condResult <= condReq.valid &&
        (evalCond(condReq.sel, flags_reg, portValue) ^
         condReq.invert);
    end
  end

  assign testStickyOvf = condReq.valid &&
    (condReq.sel == alu_flags_pkg::COND_STK_OVF);
  assign testStickyNrm = condReq.valid &&
    (condReq.sel == alu_flags_pkg::COND_STK_NRM);

  // result-derived flag terms
  assign res = aluResult.result;
  assign resNormalized =
    ((&res[`BIT_TOP:`BIT_MID]) || !(|res[`BIT_TOP:`BIT_MID])) &&
    (res[`BIT_MID] != res[`BIT_BELOW_MID]);
  assign resBeyond32 =
    !((&res[`BIT_TOP:`BIT_MID]) ||
      !(|res[`BIT_TOP:`BIT_MID]));

  always_comb begin
    flags_next = flags_reg;
    if (flagsWrite) begin
      flags_next = alu_flags_pkg::condition_flags_t'(
        pwdata[`FLAGS_W-1:0]);
    end
    unique case ({loopLevelInc, loopLevelDec})
      2'b10:   flags_next.loopLevel = flags_reg.loopLevel + 2'h1;
      2'b01:   flags_next.loopLevel = flags_reg.loopLevel - 2'h1;
      default: flags_next.loopLevel = flags_next.loopLevel;
    endcase
    if (testStickyOvf) begin
      flags_next.stickyOverflow = 1'b0;
    end
    if (testStickyNrm) begin
      flags_next.stickyNormalized = 1'b0;
    end
    if (aluResult.valid) begin
      flags_next.sign            = res[`BIT_TOP];
      flags_next.zero            = (res == '0);
      flags_next.carry           = aluResult.carry39;
      flags_next.overflowFlag    = aluResult.overflow40;
      flags_next.beyond32Flag    = resBeyond32;
      flags_next.normalized      = resNormalized;
      flags_next.resultBit16Flag = res[`BIT_PARITY];
      if (aluResult.overflow40) begin
        flags_next.stickyOverflow = 1'b1;
      end
      if (resNormalized) begin
        flags_next.stickyNormalized = 1'b1;
      end
      if (aluResult.op != alu_flags_pkg::OP_DOUBLE_PRECISION_MULTIPLY) begin
        flags_next.carryOutMid = aluResult.carry31;
      end
      if (aluResult.op == alu_flags_pkg::OP_BIT_TEST) begin
        flags_next.testResult = aluResult.testBit;
      end
      if (aluResult.op == alu_flags_pkg::OP_SHIFT) begin
        flags_next.testResult = aluResult.shiftOut;
      end
      if (aluResult.op == alu_flags_pkg::OP_DIV_FIRST ||
          aluResult.op == alu_flags_pkg::OP_DIV_STEP) begin
        flags_next.nextQuotientComplement =
          !aluResult.quotientBit;
      end
      if (aluResult.op == alu_flags_pkg::OP_SIGN_CMP) begin
        flags_next.compareSign =
          aluResult.signLeft ^ aluResult.signRight;
      end
    end
    flags_next.reserved = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= alu_flags_pkg::condition_flags_t'(
        `FLAGS_RESET);
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flagsOut <= alu_flags_pkg::condition_flags_t'(`FLAGS_RESET);
    end else begin
      flagsOut <= flags_next;
    end
  end

  // accumulator zeroing
  always_ff @(posedge clk) begin
    if (reset) begin
      zeroValid <= 1'b0;
      zeroValue <= '0;
    end else begin
      zeroValid <= zeroReq.valid;
      if (zeroReq.valid) begin
        unique case (zeroReq.sel)
          alu_flags_pkg::ZERO_ALL:
            zeroValue <= '0;
          alu_flags_pkg::ZERO_UPPER:
            zeroValue <= {{`UPPER_W{1'b0}},
                          zeroReq.value[`LOW_HI:0]};
          alu_flags_pkg::ZERO_LOW:
            zeroValue <= {zeroReq.value[`BIT_TOP:`UPPER_LO],
                          {`LOW_W{1'b0}}};
          alu_flags_pkg::ZERO_EXT:
            zeroValue <= {{`EXT_W{1'b0}},
                          zeroReq.value[`EXT_LO-1:0]};
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- src/alu_flags_cfg.svh
`ifndef ALU_FLAGS_CFG_SVH
`define ALU_FLAGS_CFG_SVH

`define RESULT_W        40
`define FLAGS_W         16
`define PORT_W          8
`define APB_ADDR_W      8
`define APB_DATA_W      32

`define FLAGS_RESET     16'h0000

`define OFF_FLAGS       8'h00
`define OFF_PORT_SENS   8'h04
`define OFF_PORT_STATE  8'h08

`define BIT_MID         31
`define BIT_TOP         39
`define BIT_BELOW_MID   30
`define BIT_PARITY      16
`define EXT_LO          32
`define LOW_HI          15
`define UPPER_LO        16
`define EXT_W           8
`define UPPER_W         24
`define LOW_W           16

`endif

//--- src/alu_flags_pkg.sv
package alu_flags_pkg;

  typedef struct packed {
    logic [1:0] loopLevel;
    logic       reserved;
    logic       testResult;
    logic       carryOutMid;
    logic       nextQuotientComplement;
    logic       compareSign;
    logic       resultBit16Flag;
    logic       stickyNormalized;
    logic       normalized;
    logic       beyond32Flag;
    logic       stickyOverflow;
    logic       overflowFlag;
    logic       zero;
    logic       carry;
    logic       sign;
  } condition_flags_t;

  typedef enum logic [2:0] {
    OP_ARITH     = 3'h0,
    OP_DOUBLE_PRECISION_MULTIPLY     = 3'h1,
    OP_SHIFT     = 3'h2,
    OP_BIT_TEST  = 3'h3,
    OP_SIGN_CMP  = 3'h4,
    OP_DIV_FIRST = 3'h5,
    OP_DIV_STEP  = 3'h6,
    OP_RESTORE   = 3'h7
  } alu_op_t;

  typedef struct packed {
    logic         valid;
    alu_op_t      op;
    logic [39:0]  result;
    logic         carry39;
    logic         carry31;
    logic         overflow40;
    logic         shiftOut;
    logic         testBit;
    logic         quotientBit;
    logic         signLeft;
    logic         signRight;
  } alu_result_t;

  typedef enum logic [4:0] {
    COND_ALWAYS  = 5'h00,
    COND_ZERO    = 5'h01,
    COND_LESS    = 5'h02,
    COND_AT_MOST = 5'h03,
    COND_CARRY   = 5'h04,
    COND_SIGN    = 5'h05,
    COND_EXT     = 5'h06,
    COND_OVF     = 5'h07,
    COND_STK_OVF = 5'h08,
    COND_NORM    = 5'h09,
    COND_STK_NRM = 5'h0A,
    COND_BIT16   = 5'h0B,
    COND_CARRY31 = 5'h0C,
    COND_TEST    = 5'h0D,
    COND_PORT0   = 5'h10,
    COND_PORT1   = 5'h11,
    COND_PORT2   = 5'h12,
    COND_PORT3   = 5'h13,
    COND_PORT4   = 5'h14,
    COND_PORT5   = 5'h15,
    COND_PORT6   = 5'h16,
    COND_PORT7   = 5'h17
  } cond_sel_t;

  typedef struct packed {
    logic      valid;
    cond_sel_t sel;
    logic      invert;
  } cond_req_t;

  typedef enum logic [1:0] {
    ZERO_ALL   = 2'h0,
    ZERO_UPPER = 2'h1,
    ZERO_LOW   = 2'h2,
    ZERO_EXT   = 2'h3
  } accum_zero_t;

  typedef struct packed {
    logic        valid;
    accum_zero_t sel;
    logic [39:0] value;
  } accum_zero_req_t;

endpackage

//--- tb/alu_flags_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "alu_flags_cfg.svh"
module alu_flags_chk (
  input wire logic                            clk,
  input wire logic                            reset,
  input wire alu_flags_pkg::alu_result_t      aluResult,
  input wire alu_flags_pkg::cond_req_t        condReq,
  input wire logic                            condValid,
  input wire logic                            condResult,
  input wire alu_flags_pkg::accum_zero_req_t  zeroReq,
  input wire logic                            zeroValid,
  input wire logic [`RESULT_W-1:0]            zeroValue,
  input wire alu_flags_pkg::condition_flags_t flagsOut
);
  logic arith;
  logic nrm;
  assign arith = aluResult.valid && aluResult.op == alu_flags_pkg::OP_ARITH;
  assign nrm = aluResult.result[39:30] inside {10'h3FE, 10'h001};
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_rst;
    disable iff (1'b0) reset |=> flagsOut == 16'h0000 && !condValid;
  endproperty
  a_rst: assert property (p_rst)
    else $error("flags not cleared by reset");
  property p_resv;
    flagsOut.reserved == 1'b0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved flag bit set");
  property p_zero;
    arith |=> flagsOut.zero == ($past(aluResult.result) == 40'h0);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  property p_sgn;
    arith |=> flagsOut.sign == $past(aluResult.result[39])
      && flagsOut.carry == $past(aluResult.carry39);
  endproperty
  a_sgn: assert property (p_sgn)
    else $error("sign or carry flag wrong");
  property p_norm;
    arith |=> flagsOut.normalized == $past(nrm)
      && flagsOut.resultBit16Flag == $past(aluResult.result[16]);
  endproperty
  a_norm: assert property (p_norm)
    else $error("normalized or bit16 flag wrong");
  property p_sovf;
    arith && aluResult.overflow40 |=> flagsOut.stickyOverflow
      && flagsOut.overflowFlag;
  endproperty
  a_sovf: assert property (p_sovf)
    else $error("overflow flags not set");
  property p_mid;
    aluResult.valid && aluResult.op == alu_flags_pkg::OP_DOUBLE_PRECISION_MULTIPLY
      |=> $stable(flagsOut.carryOutMid);
  endproperty
  a_mid: assert property (p_mid)
    else $error("mid carry changed by double multiply");
  property p_cnd;
    condValid == $past(condReq.valid);
  endproperty
  a_cnd: assert property (p_cnd)
    else $error("condition answer not one cycle after request");
  property p_lt;
    condReq.valid && condReq.sel == alu_flags_pkg::COND_LESS |=>
      condResult == ($past(flagsOut.sign) ^ $past(flagsOut.overflowFlag)
      ^ $past(condReq.invert));
  endproperty
  a_lt: assert property (p_lt)
    else $error("less-than condition wrong");
  property p_zall;
    zeroReq.valid && zeroReq.sel == alu_flags_pkg::ZERO_ALL
      |=> zeroValid && zeroValue == 40'h0;
  endproperty
  a_zall: assert property (p_zall)
    else $error("full accumulator clear wrong");
endmodule
`default_nettype wire

//--- tb/alu_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module alu_seq_model (
  input  wire logic                      clk,
  output alu_flags_pkg::alu_result_t     aluResult,
  output alu_flags_pkg::cond_req_t       condReq,
  output alu_flags_pkg::accum_zero_req_t zeroReq,
  output logic                           loopLevelInc,
  output logic                           loopLevelDec
);
  initial begin
    aluResult = '0;
    condReq = '0;
    zeroReq = '0;
    loopLevelInc = 1'b0;
    loopLevelDec = 1'b0;
  end
  // idle payloads are inverted so stale values never look valid
  task automatic alu(input alu_flags_pkg::alu_result_t a);
    @(posedge clk);
    aluResult <= a;
    @(posedge clk);
    aluResult <= {1'b0, ~a[50:0]};
  endtask
  task automatic cond(input logic [4:0] s, input logic i);
    @(posedge clk);
    condReq <= {1'b1, s, i};
    @(posedge clk);
    condReq <= {1'b0, ~s, ~i};
  endtask
  task automatic zero(input logic [1:0] s, input logic [39:0] v);
    @(posedge clk);
    zeroReq <= {1'b1, s, v};
    @(posedge clk);
    zeroReq <= {1'b0, ~s, ~v};
  endtask
  task automatic loop(input logic up);
    @(posedge clk);
    loopLevelInc <= up;
    loopLevelDec <= !up;
    @(posedge clk);
    loopLevelInc <= 1'b0;
    loopLevelDec <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/alu_flags_and_conditions_tb.sv
`timescale 1ns/1ns
`default_nettype none
module alu_flags_and_conditions_tb;
  logic                            clk, reset, psel, penable, pwrite;
  logic                            pready, pslverr, condValid, condResult;
  logic                            zeroValid, loopLevelInc, loopLevelDec;
  logic [7:0]                      paddr, portPins, pinExp;
  logic [31:0]                     pwdata, prdata, seed, r;
  logic [39:0]                     zeroValue, v;
  logic [39:0]                     expQ[$];
  logic [39:0]                     zm[4];
  alu_flags_pkg::alu_result_t      aluResult, a;
  alu_flags_pkg::cond_req_t        condReq;
  alu_flags_pkg::accum_zero_req_t  zeroReq;
  alu_flags_pkg::condition_flags_t ef;
  int                              k, bad_count, samples_checked;
  alu_seq_model i_seq (
    .clk(clk), .aluResult(aluResult), .condReq(condReq),
    .zeroReq(zeroReq), .loopLevelInc(loopLevelInc),
    .loopLevelDec(loopLevelDec));
  alu_flags_and_conditions i_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aluResult(aluResult),
    .loopLevelInc(loopLevelInc), .loopLevelDec(loopLevelDec),
    .condReq(condReq), .condValid(condValid), .condResult(condResult),
    .zeroReq(zeroReq), .zeroValid(zeroValid), .zeroValue(zeroValue),
    .portPins(portPins), .flagsOut());
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [39:0] x);
    logic [39:0] e;
    e = expQ.size() > 0 ? expQ.pop_front() : 40'hX;
    samples_checked++;
    if (x !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, x);
    end
  endtask
  always @(posedge clk) begin
    if (condValid === 1'b1) chk("condResult", {39'h0, condResult});
    if (zeroValid === 1'b1) chk("zeroValue", zeroValue);
    if (psel && penable && !pwrite && pready === 1'b1) begin
      chk("prdata", {7'h0, pslverr, prdata});
    end
  end
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, input logic [39:0] e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    if (!w) expQ.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic upd(input alu_flags_pkg::alu_result_t x);
    ef.sign = x.result[39];
    ef.carry = x.carry39;
    ef.zero = x.result == 40'h0;
    ef.overflowFlag = x.overflow40;
    ef.stickyOverflow |= x.overflow40;
    ef.beyond32Flag = !(x.result[39:31] inside {9'h000, 9'h1FF});
    ef.normalized = x.result[39:30] inside {10'h3FE, 10'h001};
    ef.stickyNormalized |= ef.normalized;
    ef.resultBit16Flag = x.result[16];
    if (x.op != alu_flags_pkg::OP_DOUBLE_PRECISION_MULTIPLY) ef.carryOutMid = x.carry31;
    if (x.op == alu_flags_pkg::OP_SHIFT) ef.testResult = x.shiftOut;
    if (x.op == alu_flags_pkg::OP_BIT_TEST) ef.testResult = x.testBit;
    if (x.op == alu_flags_pkg::OP_SIGN_CMP) begin
      ef.compareSign = x.signLeft ^ x.signRight;
    end
    if (x.op inside {alu_flags_pkg::OP_DIV_FIRST,
                     alu_flags_pkg::OP_DIV_STEP}) begin
      ef.nextQuotientComplement = !x.quotientBit;
    end
  endtask
  task automatic tc(input int s, input logic i);
    logic [23:0] c;
    c = {pinExp, 2'b00, ef.testResult, ef.carryOutMid, ef.resultBit16Flag,
         ef.stickyNormalized, ef.normalized, ef.stickyOverflow,
         ef.overflowFlag, ef.beyond32Flag, ef.sign, ef.carry,
         (ef.sign ^ ef.overflowFlag) | ef.zero, ef.sign ^ ef.overflowFlag,
         ef.zero, 1'b1};
    expQ.push_back({39'h0, c[s] ^ i});
    i_seq.cond(s[4:0], i);
    if (s == 8) ef.stickyOverflow = 1'b0;
    if (s == 10) ef.stickyNormalized = 1'b0;
  endtask
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, portPins} = '0;
    reset = 1'b1;
    seed = 32'h381D;
    ef = '0;
    zm = '{40'h0, 40'h000000FFFF, 40'hFFFFFF0000, 40'h00FFFFFFFF};
    bad_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, 40'h0);
    apb(1'b1, 8'h00, 32'hFFFF, 40'h0);
    apb(1'b0, 8'h00, 32'h0, 40'hDFFF);
    apb(1'b0, 8'h0C, 32'h0, 40'h0100000000);
    apb(1'b1, 8'h00, 32'h0, 40'h0);
    repeat (3) i_seq.loop(1'b1);
    apb(1'b0, 8'h00, 32'h0, 40'hC000);
    i_seq.loop(1'b0);
    apb(1'b0, 8'h00, 32'h0, 40'h8000);
    repeat (2) i_seq.loop(1'b1);
    apb(1'b0, 8'h00, 32'h0, 40'h0);
    for (k = 0; k < 24; k++) begin
      r = rnd();
      a = {1'b1, k[2:0], r[23:16], rnd(), r[31:24]};
      if (k % 3 == 1) a.result[39:30] = r[16] ? 10'h3FE : 10'h001;
      if (k == 4) a.result = 40'h0;
      i_seq.alu(a);
      upd(a);
      apb(1'b0, 8'h00, 32'h0, {24'h0, ef});
      // the read above also
    end
    for (k = 0; k < 4; k++) begin
      r = rnd();
      v = {r[7:0], rnd()};
      expQ.push_back(v & zm[k]);
      i_seq.zero(k[1:0], v);
    end
    r = rnd();
    pinExp = r[7:0];
    @(posedge clk);
    portPins <= pinExp;
    repeat (3) @(posedge clk);
    apb(1'b1, 8'h08, 32'hFF, 40'h0);
    apb(1'b0, 8'h08, 32'h0, {32'h0, pinExp});
    for (k = 0; k < 24; k++) begin
      if (k < 14 || k > 15) begin
        tc(k, 1'b0);
        tc(k, 1'b1);
      end
    end
    apb(1'b0, 8'h00, 32'h0, {24'h0, ef});
    apb(1'b1, 8'h04, 32'h1, 40'h0);
    apb(1'b0, 8'h04, 32'h0, 40'h1);
    @(posedge clk);
    portPins[0] <= 1'b1;
    repeat (3) @(posedge clk);
    portPins[0] <= 1'b0;
    repeat (3) @(posedge clk);
    pinExp[0] = 1'b1;
    tc(16, 1'b0);
    pinExp[0] = 1'b0;
    tc(16, 1'b0);
    for (k = 0; k < 20 && expQ.size() > 0; k++) @(posedge clk);
    if (expQ.size() > 0) bad_count++;
    complete_run();
  end
endmodule
bind alu_flags_and_conditions alu_flags_chk i_chk (
  .clk(clk), .reset(reset), .aluResult(aluResult), .condReq(condReq),
  .condValid(condValid), .condResult(condResult), .zeroReq(zeroReq),
  .zeroValid(zeroValid), .zeroValue(zeroValue), .flagsOut(flagsOut));
`default_nettype wire
